// ---- inc/remap_cache_pkg.sv ----
package remap_cache_pkg;
    // Register map, byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_INVAL = 4'h8;
    // Control fields
    localparam int CTRL_TMS_LO = 0;
    localparam int CTRL_TMS_HI = 1;
    localparam int CTRL_FIVE_LEVEL = 2;
    localparam int CTRL_CM = 3;
    localparam int CTRL_MIX = 4;
    localparam logic [31:0] CTRL_MASK = 32'h0000_001F;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] TMS_SCALABLE = 2'h1;
    // Invalidate fields, write one to drop every entry of that cache
    localparam int INV_CTX = 0;
    localparam int INV_SPACE = 1;
    localparam int INV_TLB = 2;
    localparam int INV_IRQ = 3;
    // Address tag bit positions
    localparam int MAX_GUEST_ADDR_WIDTH = 48;
    localparam int HOST_ADDR_WIDTH = 52;
    localparam int N_FIVE = 56;
    localparam int N_FOUR = 47;
    localparam int LO_4K = 12;
    localparam int LO_2M = 21;
    localparam int LO_1G = 30;
    localparam int PS_FS_HI = 56;
    localparam int PS_LO_L5 = 48;
    localparam int PS_LO_L4 = 39;
    localparam int PS_LO_L3 = 30;
    localparam int PS_LO_L2 = 21;
    localparam int HPT_LO_L4 = 41;
    localparam int HPT_LO_L3 = 33;
    localparam int HPT_LO_L2 = 25;
    localparam int HPT_LO_L1 = 17;
    localparam logic [15:0] RESERVED_DID = 16'h0000;
    localparam int IDX_W = 2;
    localparam int NE = 4;

    typedef enum logic [1:0] {MAP_FIRST, MAP_NESTED, MAP_SECOND, MAP_PASS} map_kind_t;
    typedef enum logic [1:0] {PG_4K, PG_2M, PG_1G} page_size_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [15:0] sid;
        logic [15:0] did;
        logic [19:0] default_space_id;
    } ctx_fill_t;

    typedef struct packed {
        logic valid;
        logic fault;
        logic [15:0] sid;
        logic [19:0] pasid;
        logic [15:0] did;
    } space_fill_t;

    typedef struct packed {
        logic valid;
        logic fill;
        logic pasid_valid;
        logic [15:0] sid;
        logic [19:0] pasid;
        map_kind_t kind;
        page_size_t size;
        logic [63:0] addr;
    } tlb_req_t;

    typedef struct packed {
        logic second_stage;
        logic [2:0] level;
        logic [63:0] addr;
    } walk_req_t;

    typedef struct packed {
        logic valid;
        logic fill;
        logic [15:0] index;
    } irq_req_t;

    typedef struct packed {
        logic ctx_hit;
        logic space_hit;
        logic tlb_hit;
        logic irq_hit;
        logic [15:0] did;
        logic [19:0] pasid;
        logic [63:0] page_tag;
        logic [63:0] ps_tag;
        logic [63:0] hpt_tag;
    } lookup_rsp_t;
endpackage

// ---- design/remap_cache_tagging.sv ----
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
// Summary of operation
// - Translation entries tagged by page number, low bit by size, top bit by mapping.
// - First-stage and nested top tag bit is 56 for five-level, 47 four-level.
// - Paging-structure tags: low bit 48/39/30/21 per level, top 56 or guest width.
// - Host-permission tags span host width minus one down to 41/33/25/17.
// - Scalable request without space id looks up using context default space id.
// - Such fills carry the default space id but stay marked as no-id allocations.
// - Optionally, id-carrying requests may hit no-id entries of the same requester.
// - Interrupt remap cache entries are tagged by interrupt index.
// - Context cache holds context entries indexed by source id.
// - Without caching mode, faulting context entries are never cached.
// - With caching mode, faulting legacy context entries carry domain tag zero.
// - Space-id cache holds table entries and works only in scalable mode.
// - Without caching mode, faulting space-id table entries are never cached.
// - With caching mode, faulting space-id entries carry domain tag zero.
// - A lookup hits only when every tag of that cache matches, mixed TLB hits and TLB space ids outside scalable mode excepted.
module remap_cache_tagging (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input remap_cache_pkg::ctx_fill_t ctx_fill,
    input remap_cache_pkg::space_fill_t space_fill,
    input remap_cache_pkg::tlb_req_t tlb_req,
    input remap_cache_pkg::walk_req_t walk_req,
    input remap_cache_pkg::irq_req_t irq_req,
    output remap_cache_pkg::lookup_rsp_t rsp
);
    import remap_cache_pkg::*;

    function automatic logic [63:0] span(input int hi, input int lo);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 64; i++) begin
            m[i] = (i <= hi) && (i >= lo);
        end
        return m;
    endfunction

    function automatic logic [63:0] page_tag(input tlb_req_t r, input logic five);
        int hi;
        int lo;
        case (r.size)
            PG_2M: lo = LO_2M;
            PG_1G: lo = LO_1G;
            default: lo = LO_4K;
        endcase
        case (r.kind)
            MAP_SECOND: hi = MAX_GUEST_ADDR_WIDTH;
            MAP_PASS: hi = HOST_ADDR_WIDTH;
            default: hi = five ? N_FIVE : N_FOUR;
        endcase
        return r.addr & span(hi, lo);
    endfunction

    function automatic logic [63:0] ps_tag(input walk_req_t w);
        int lo;
        case (w.level)
            3'd5: lo = PS_LO_L5;
            3'd4: lo = PS_LO_L4;
            3'd3: lo = PS_LO_L3;
            default: lo = PS_LO_L2;
        endcase
        return w.addr & span(w.second_stage ? MAX_GUEST_ADDR_WIDTH : PS_FS_HI, lo);
    endfunction

    function automatic logic [63:0] hpt_tag(input walk_req_t w);
        int lo;
        case (w.level)
            3'd4: lo = HPT_LO_L4;
            3'd3: lo = HPT_LO_L3;
            3'd2: lo = HPT_LO_L2;
            default: lo = HPT_LO_L1;
        endcase
        return w.addr & span(HOST_ADDR_WIDTH - 1, lo);
    endfunction

    // Xor hash so one space id used by many sources spreads over slots
    function automatic logic [IDX_W-1:0] slot(input logic [15:0] a, input logic [15:0] b);
        return a[IDX_W-1:0] ^ b[IDX_W-1:0];
    endfunction

    logic [31:0] ctrl_q;
    logic [31:0] rdata_q;
    logic [NE-1:0] ctx_v_q, ctx_v_d, sp_v_q, sp_v_d, tlb_v_q, tlb_v_d, irq_v_q, irq_v_d;
    logic [15:0] ctx_sid_q[NE];
    logic [15:0] ctx_did_q[NE];
    logic [19:0] ctx_dflt_q[NE];
    logic [15:0] sp_sid_q[NE];
    logic [19:0] sp_pasid_q[NE];
    logic [15:0] sp_did_q[NE];
    logic [NE-1:0] tlb_np_q;
    logic [15:0] tlb_sid_q[NE];
    logic [19:0] tlb_pasid_q[NE];
    logic [63:0] tlb_tag_q[NE];
    logic [1:0] tlb_kind_q[NE];
    logic [1:0] tlb_size_q[NE];
    logic [15:0] irq_idx_q[NE];
    lookup_rsp_t rsp_q, rsp_d;

    wire scalable = ctrl_q[CTRL_TMS_HI:CTRL_TMS_LO] == TMS_SCALABLE;
    wire five_level = ctrl_q[CTRL_FIVE_LEVEL];
    wire cm = ctrl_q[CTRL_CM];
    wire mix_en = ctrl_q[CTRL_MIX];
    wire [3:0] inv_w = (reg_wr && reg_addr == REG_INVAL) ? reg_wdata[3:0] : 4'h0;
    wire [31:0] status_w = {16'h0000, irq_v_q, tlb_v_q, sp_v_q, ctx_v_q};

    // Fill side
    wire [IDX_W-1:0] cf_i = slot(ctx_fill.sid, 16'h0000);
    wire ctx_alloc = ctx_fill.valid && (!ctx_fill.fault || cm);
    // Scalable entries have no domain tag, so zero there as well
    wire [15:0] ctx_did_w = (!scalable && !ctx_fill.fault) ? ctx_fill.did : RESERVED_DID;
    wire [IDX_W-1:0] sf_i = slot(space_fill.pasid[15:0], space_fill.sid);
    wire sp_alloc = space_fill.valid && scalable && (!space_fill.fault || cm);
    wire [15:0] sp_did_w = space_fill.fault ? RESERVED_DID : space_fill.did;

    // Lookup side
    wire lk = tlb_req.valid && !tlb_req.fill;
    wire [IDX_W-1:0] lc_i = slot(tlb_req.sid, 16'h0000);
    wire ctx_hit = ctx_v_q[lc_i] && ctx_sid_q[lc_i] == tlb_req.sid;
    wire [19:0] eff_pasid = tlb_req.pasid_valid ? tlb_req.pasid : ctx_dflt_q[lc_i];
    wire [IDX_W-1:0] ls_i = slot(eff_pasid[15:0], tlb_req.sid);
    wire sp_hit = scalable && (tlb_req.pasid_valid || ctx_hit) && sp_v_q[ls_i]
        && sp_sid_q[ls_i] == tlb_req.sid && sp_pasid_q[ls_i] == eff_pasid;
    wire [63:0] cur_tag = page_tag(tlb_req, five_level);
    wire [IDX_W-1:0] t_i = lc_i;
    wire np_match = tlb_np_q[t_i] && !tlb_req.pasid_valid;
    wire id_match = !tlb_np_q[t_i] && tlb_req.pasid_valid && tlb_pasid_q[t_i] == tlb_req.pasid;
    wire mix_match = mix_en && tlb_np_q[t_i] && tlb_req.pasid_valid;
    wire pasid_ok = !scalable || np_match || id_match || mix_match;
    wire tlb_hit = tlb_v_q[t_i] && tlb_sid_q[t_i] == tlb_req.sid && tlb_tag_q[t_i] == cur_tag
        && tlb_kind_q[t_i] == tlb_req.kind && tlb_size_q[t_i] == tlb_req.size
        && pasid_ok;
    wire tlb_alloc = tlb_req.valid && tlb_req.fill;
    wire [IDX_W-1:0] ir_i = irq_req.index[IDX_W-1:0];
    wire irq_hit = irq_v_q[ir_i] && irq_idx_q[ir_i] == irq_req.index;

    // A fill in the cycle of an invalidate survives it
    always_comb begin
        ctx_v_d = inv_w[INV_CTX] ? '0 : ctx_v_q;
        sp_v_d = inv_w[INV_SPACE] ? '0 : sp_v_q;
        tlb_v_d = inv_w[INV_TLB] ? '0 : tlb_v_q;
        irq_v_d = inv_w[INV_IRQ] ? '0 : irq_v_q;
        if (ctx_alloc) begin
            ctx_v_d[cf_i] = 1'b1;
        end
        if (sp_alloc) begin
            sp_v_d[sf_i] = 1'b1;
        end
        if (tlb_alloc) begin
            tlb_v_d[t_i] = 1'b1;
        end
        if (irq_req.valid && irq_req.fill) begin
            irq_v_d[ir_i] = 1'b1;
        end
    end

    always_comb begin
        rsp_d = '0;
        rsp_d.ctx_hit = lk && ctx_hit;
        rsp_d.space_hit = lk && sp_hit;
        rsp_d.tlb_hit = lk && tlb_hit;
        rsp_d.irq_hit = irq_req.valid && !irq_req.fill && irq_hit;
        rsp_d.did = sp_hit ? sp_did_q[ls_i] : ctx_did_q[lc_i];
        rsp_d.pasid = eff_pasid;
        rsp_d.page_tag = cur_tag;
        rsp_d.ps_tag = ps_tag(walk_req);
        rsp_d.hpt_tag = hpt_tag(walk_req);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RESET;
            rdata_q <= '0;
            rsp_q <= '0;
            ctx_v_q <= '0;
            sp_v_q <= '0;
            tlb_v_q <= '0;
            irq_v_q <= '0;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) begin
                ctrl_q <= reg_wdata & CTRL_MASK;
            end
            rdata_q <= !reg_rd ? '0 : reg_addr == REG_CTRL ? ctrl_q :
                reg_addr == REG_STATUS ? status_w : '0;
            rsp_q <= rsp_d;
            ctx_v_q <= ctx_v_d;
            sp_v_q <= sp_v_d;
            tlb_v_q <= tlb_v_d;
            irq_v_q <= irq_v_d;
        end
    end

    // Entry payloads need no reset; valid bits guard them
    always_ff @(posedge clk) begin
        if (ctx_alloc) begin
            ctx_sid_q[cf_i] <= ctx_fill.sid;
            ctx_did_q[cf_i] <= ctx_did_w;
            ctx_dflt_q[cf_i] <= ctx_fill.default_space_id;
        end
        if (sp_alloc) begin
            sp_sid_q[sf_i] <= space_fill.sid;
            sp_pasid_q[sf_i] <= space_fill.pasid;
            sp_did_q[sf_i] <= sp_did_w;
        end
        if (tlb_alloc) begin
            tlb_np_q[t_i] <= !tlb_req.pasid_valid;
            tlb_sid_q[t_i] <= tlb_req.sid;
            tlb_pasid_q[t_i] <= eff_pasid;
            tlb_tag_q[t_i] <= cur_tag;
            tlb_kind_q[t_i] <= tlb_req.kind;
            tlb_size_q[t_i] <= tlb_req.size;
        end
        if (irq_req.valid && irq_req.fill) begin
            irq_idx_q[ir_i] <= irq_req.index;
        end
    end

    assign reg_rdata = rdata_q;
    assign rsp = rsp_q;

    sequence ctx_fault_fill_s;
        ctx_fill.valid && ctx_fill.fault;
    endsequence

    sequence space_fault_fill_s;
        space_fill.valid && space_fill.fault;
    endsequence

    // No-id fill; the refill check adds one quiet cycle, then the matching lookup
    sequence tlb_fill_s;
        tlb_alloc && !tlb_req.pasid_valid;
    endsequence

    sequence irq_fill_s;
        irq_req.valid && irq_req.fill;
    endsequence

    // Payloads start unknown, so the check comparing old payloads (ctx_no_fault_a) gates on a valid slot
    ctx_no_fault_a: assert property (@(posedge clk) disable iff (rst)
        ctx_fault_fill_s ##0 !cm ##0 ctx_v_q[cf_i] |=>
        ctx_sid_q[$past(cf_i)] == $past(ctx_sid_q[cf_i])
        && ctx_did_q[$past(cf_i)] == $past(ctx_did_q[cf_i])
        && ctx_v_q[$past(cf_i)])
        else $error("faulting context entry cached");
    ctx_fault_a: assert property (@(posedge clk) disable iff (rst)
        ctx_fault_fill_s ##0 !cm ##0 !ctx_v_q[cf_i] ##0 !inv_w[INV_CTX] |=> !ctx_v_q[$past(cf_i)])
        else $error("faulting context entry became valid");
    ctx_reserved_a: assert property (@(posedge clk) disable iff (rst)
        ctx_fault_fill_s ##0 cm |=> ctx_v_q[$past(cf_i)] && ctx_did_q[$past(cf_i)] == RESERVED_DID)
        else $error("faulting context entry not tagged zero");
    space_mode_a: assert property (@(posedge clk) disable iff (rst)
        !scalable |=> !rsp_q.space_hit)
        else $error("space cache used outside scalable mode");
    space_fault_a: assert property (@(posedge clk) disable iff (rst)
        space_fault_fill_s ##0 !cm ##0 !sp_v_q[sf_i] ##0 !inv_w[INV_SPACE] |=> !sp_v_q[$past(sf_i)])
        else $error("faulting space entry cached");
    space_reserved_a: assert property (@(posedge clk) disable iff (rst)
        space_fault_fill_s ##0 cm ##0 scalable |=> sp_did_q[$past(sf_i)] == RESERVED_DID)
        else $error("faulting space entry not tagged zero");
    tlb_default_a: assert property (@(posedge clk) disable iff (rst)
        tlb_alloc && !tlb_req.pasid_valid |=>
        tlb_np_q[$past(t_i)] && tlb_pasid_q[$past(t_i)] == $past(ctx_dflt_q[lc_i]))
        else $error("no-id fill lost default space id");
    page_low_a: assert property (@(posedge clk) disable iff (rst)
        tlb_req.size == PG_1G |=> rsp_q.page_tag[29:0] == 30'h0000_0000)
        else $error("1G page tag keeps low bits");
    page_top_a: assert property (@(posedge clk) disable iff (rst)
        tlb_req.kind == MAP_FIRST && !five_level |=> rsp_q.page_tag[63:48] == 16'h0000)
        else $error("four-level tag above bit 47");
    tlb_refill_a: assert property (@(posedge clk) disable iff (rst)
        tlb_fill_s ##1 !tlb_alloc && !inv_w[INV_TLB] ##1 lk && !tlb_req.pasid_valid
        && tlb_req.sid == $past(tlb_req.sid, 2) && cur_tag == $past(cur_tag, 2)
        && tlb_req.kind == $past(tlb_req.kind, 2) && tlb_req.size == $past(tlb_req.size, 2)
        |=> rsp_q.tlb_hit)
        else $error("matching lookup missed a fresh entry");
    irq_hit_a: assert property (@(posedge clk) disable iff (rst)
        irq_fill_s ##1 !(irq_req.valid && irq_req.fill) && !inv_w[INV_IRQ] ##1
        irq_req.valid && !irq_req.fill && irq_req.index == $past(irq_req.index, 2)
        |=> rsp_q.irq_hit)
        else $error("interrupt index lookup missed");
    tlb_mix_off_a: assert property (@(posedge clk) disable iff (rst)
        lk && scalable && !mix_en && tlb_req.pasid_valid && tlb_np_q[t_i] |=> !rsp_q.tlb_hit)
        else $error("id request hit a no-id entry");
    ps_low_a: assert property (@(posedge clk) disable iff (rst)
        walk_req.level == 3'd5 && !walk_req.second_stage |=> rsp_q.ps_tag[PS_LO_L5-1:0] == '0
        && rsp_q.ps_tag[63:PS_FS_HI+1] == '0)
        else $error("fifth-level tag outside its span");
    hpt_span_a: assert property (@(posedge clk) disable iff (rst)
        walk_req.level == 3'd1 |=> rsp_q.hpt_tag[63:HOST_ADDR_WIDTH] == '0
        && rsp_q.hpt_tag[HPT_LO_L1-1:0] == '0)
        else $error("host permission tag outside its span");
endmodule

// ---- testbench/endpoint_request_model.sv ----
`timescale 1ns/10ps
module endpoint_request_model
    import remap_cache_pkg::*;
(
    input wire logic clk,
    output remap_cache_pkg::ctx_fill_t ctx_fill,
    output remap_cache_pkg::space_fill_t space_fill,
    output remap_cache_pkg::tlb_req_t tlb_req,
    output remap_cache_pkg::walk_req_t walk_req,
    output remap_cache_pkg::irq_req_t irq_req
);
    initial begin
        ctx_fill = '0;
        space_fill = '0;
        tlb_req = '0;
        walk_req = '0;
        irq_req = '0;
    end
    // Released fields show inverted garbage, so a stale value never looks valid
    task automatic ctx(input logic flt, input logic [15:0] sid, input logic [15:0] did,
                       input logic [19:0] dflt);
        ctx_fill_t t;
        t = '{1'b1, flt, sid, did, dflt};
        @(posedge clk);
        ctx_fill <= t;
        @(posedge clk);
        ctx_fill <= {1'b0, ~t[$bits(t)-2:0]};
        #1;
    endtask
    task automatic space(input logic flt, input logic [15:0] sid, input logic [19:0] pasid,
                         input logic [15:0] did);
        space_fill_t t;
        t = '{1'b1, flt, sid, pasid, did};
        @(posedge clk);
        space_fill <= t;
        @(posedge clk);
        space_fill <= {1'b0, ~t[$bits(t)-2:0]};
        #1;
    endtask
    task automatic tlb(input logic fill, input logic pv, input logic [15:0] sid,
                       input logic [19:0] pasid, input int k, input int s, input logic [63:0] a);
        tlb_req_t t;
        t = '{1'b1, fill, pv, sid, pasid, map_kind_t'(k), page_size_t'(s), a};
        @(posedge clk);
        tlb_req <= t;
        @(posedge clk);
        tlb_req <= {1'b0, ~t[$bits(t)-2:0]};
        #1;
    endtask
    task automatic irq(input logic fill, input logic [15:0] idx);
        @(posedge clk);
        irq_req <= '{1'b1, fill, idx};
        @(posedge clk);
        irq_req <= '{1'b0, ~fill, ~idx};
        #1;
    endtask
    task automatic walk(input logic ss, input logic [2:0] lvl, input logic [63:0] a);
        @(posedge clk);
        walk_req <= '{ss, lvl, a};
        @(posedge clk);
        walk_req <= '{~ss, ~lvl, ~a};
        #1;
    endtask
endmodule

// ---- testbench/remap_cache_tagging_tb_top.sv ----
`timescale 1ns/10ps
module remap_cache_tagging_tb_top;
    import remap_cache_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    ctx_fill_t ctx_fill;
    space_fill_t space_fill;
    tlb_req_t tlb_req;
    walk_req_t walk_req;
    irq_req_t irq_req;
    lookup_rsp_t rsp;
    int bad_count = 0;
    int samples_checked = 0;
    logic [31:0] d;
    int hi;
    int lo;
    remap_cache_tagging i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ctx_fill(ctx_fill), .space_fill(space_fill), .tlb_req(tlb_req),
        .walk_req(walk_req), .irq_req(irq_req), .rsp(rsp));
    endpoint_request_model i_ep (.clk(clk), .ctx_fill(ctx_fill), .space_fill(space_fill),
        .tlb_req(tlb_req), .walk_req(walk_req), .irq_req(irq_req));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic flush(input logic [31:0] ctrl);
        for (int i = 0; i < 4; i++) begin
            wr(REG_INVAL, 32'h0000_0001 << i);
        end
        wr(REG_CTRL, ctrl);
    endtask
    function automatic logic [63:0] span(input int h, input int l);
        span = ({64{1'b1}} << l) & ({64{1'b1}} >> (63 - h));
    endfunction
    task automatic t_regs();
        rd(REG_CTRL, d);
        chk("ctrl reset", 64'(d), 64'(CTRL_RESET));
        wr(REG_CTRL, 32'hFFFF_FFFF);
        rd(REG_CTRL, d);
        chk("ctrl mask", 64'(d), 64'(CTRL_MASK));
        rd(REG_INVAL, d);
        chk("inval read", 64'(d), 64'h0);
        rd(4'hC, d);
        chk("unmapped read", 64'(d), 64'h0);
        $display("test regs finished");
    endtask
    task automatic t_tags();
        for (int f = 0; f < 2; f++) begin
            wr(REG_CTRL, 32'(f) << CTRL_FIVE_LEVEL);
            for (int k = 0; k < 4; k++) begin
                for (int s = 0; s < 3; s++) begin
                    hi = (k < 2) ? (f == 1 ? N_FIVE : N_FOUR) :
                         (k == 2 ? MAX_GUEST_ADDR_WIDTH : HOST_ADDR_WIDTH);
                    lo = (s == 0) ? LO_4K : (s == 1 ? LO_2M : LO_1G);
                    i_ep.tlb(1'b0, 1'b0, 16'h0001, 20'h0_0000, k, s, '1);
                    chk("page_tag", rsp.page_tag, span(hi, lo));
                end
            end
        end
        for (int l = 2; l < 6; l++) begin
            lo = (l == 5) ? PS_LO_L5 : (l == 4 ? PS_LO_L4 : (l == 3 ? PS_LO_L3 : PS_LO_L2));
            i_ep.walk(1'b0, 3'(l), '1);
            chk("ps_tag first", rsp.ps_tag, span(PS_FS_HI, lo));
            i_ep.walk(1'b1, 3'(l), '1);
            chk("ps_tag second", rsp.ps_tag, span(MAX_GUEST_ADDR_WIDTH, lo));
            lo = (l == 5) ? HPT_LO_L1 : (l == 4 ? HPT_LO_L4 : (l == 3 ? HPT_LO_L3 : HPT_LO_L2));
            i_ep.walk(1'b0, (l == 5) ? 3'h1 : 3'(l), '1);
            chk("hpt_tag", rsp.hpt_tag, span(HOST_ADDR_WIDTH - 1, lo));
        end
        $display("test tags finished");
    endtask
    task automatic t_context();
        flush(32'h0000_0000);
        i_ep.ctx(1'b1, 16'h0001, 16'h0005, 20'h0_0000);
        i_ep.tlb(1'b0, 1'b0, 16'h0001, 20'h0_0000, 2, 0, 64'h0);
        chk("ctx_hit fault cm0", rsp.ctx_hit, 64'h0);
        i_ep.ctx(1'b0, 16'h0003, 16'h0009, 20'h0_0000);
        i_ep.tlb(1'b0, 1'b0, 16'h0003, 20'h0_0000, 2, 0, 64'h0);
        chk("ctx_hit", rsp.ctx_hit, 64'h1);
        chk("ctx did", rsp.did, 64'h9);
        i_ep.tlb(1'b0, 1'b0, 16'h0007, 20'h0_0000, 2, 0, 64'h0);
        chk("ctx_hit other sid", rsp.ctx_hit, 64'h0);
        i_ep.ctx(1'b1, 16'h0007, 16'h000B, 20'h0_0000);
        i_ep.tlb(1'b0, 1'b0, 16'h0003, 20'h0_0000, 2, 0, 64'h0);
        chk("ctx kept on fault", rsp.ctx_hit, 64'h1);
        chk("ctx did kept on fault", rsp.did, 64'h9);
        wr(REG_CTRL, 32'h0000_0001 << CTRL_CM);
        i_ep.ctx(1'b1, 16'h0002, 16'h0007, 20'h0_0000);
        i_ep.tlb(1'b0, 1'b0, 16'h0002, 20'h0_0000, 2, 0, 64'h0);
        chk("ctx_hit fault cm1", rsp.ctx_hit, 64'h1);
        chk("ctx did fault cm1", rsp.did, 64'(RESERVED_DID));
        $display("test context finished");
    endtask
    task automatic t_scalable();
        flush(32'(TMS_SCALABLE));
        i_ep.ctx(1'b0, 16'h0001, 16'h0004, 20'h0_0005);
        i_ep.space(1'b0, 16'h0001, 20'h0_0005, 16'h0022);
        i_ep.tlb(1'b1, 1'b0, 16'h0001, 20'h0_0000, 2, 0, 64'h0000_0000_0000_3000);
        i_ep.tlb(1'b0, 1'b0, 16'h0001, 20'h0_0000, 2, 0, 64'h0000_0000_0000_3000);
        chk("space_hit no id", rsp.space_hit, 64'h1);
        chk("effective id", rsp.pasid, 64'h5);
        chk("space did", rsp.did, 64'h22);
        chk("tlb_hit no id", rsp.tlb_hit, 64'h1);
        i_ep.tlb(1'b0, 1'b1, 16'h0001, 20'h0_0005, 2, 0, 64'h0000_0000_0000_3000);
        chk("tlb_hit id mix off", rsp.tlb_hit, 64'h0);
        wr(REG_CTRL, 32'(TMS_SCALABLE) | (32'h0000_0001 << CTRL_MIX));
        i_ep.tlb(1'b0, 1'b1, 16'h0001, 20'h0_0005, 2, 0, 64'h0000_0000_0000_3000);
        chk("tlb_hit id mix on", rsp.tlb_hit, 64'h1);
        i_ep.tlb(1'b0, 1'b0, 16'h0005, 20'h0_0000, 2, 0, 64'h0000_0000_0000_3000);
        chk("tlb_hit other sid", rsp.tlb_hit, 64'h0);
        i_ep.space(1'b1, 16'h0002, 20'h0_0002, 16'h0033);
        i_ep.tlb(1'b0, 1'b1, 16'h0002, 20'h0_0002, 2, 0, 64'h0);
        chk("space_hit fault cm0", rsp.space_hit, 64'h0);
        wr(REG_CTRL, 32'(TMS_SCALABLE) | (32'h0000_0001 << CTRL_CM));
        i_ep.space(1'b1, 16'h0002, 20'h0_0002, 16'h0033);
        i_ep.tlb(1'b0, 1'b1, 16'h0002, 20'h0_0002, 2, 0, 64'h0);
        chk("space_hit fault cm1", rsp.space_hit, 64'h1);
        chk("space did fault", rsp.did, 64'(RESERVED_DID));
        wr(REG_CTRL, 32'h0000_0000);
        i_ep.tlb(1'b0, 1'b1, 16'h0002, 20'h0_0002, 2, 0, 64'h0);
        chk("space_hit legacy mode", rsp.space_hit, 64'h0);
        flush(32'h0000_0000);
        i_ep.space(1'b0, 16'h0001, 20'h0_0001, 16'h0044);
        wr(REG_CTRL, 32'(TMS_SCALABLE));
        i_ep.tlb(1'b0, 1'b1, 16'h0001, 20'h0_0001, 2, 0, 64'h0);
        chk("space_hit legacy fill", rsp.space_hit, 64'h0);
        $display("test scalable finished");
    endtask
    task automatic t_irq();
        i_ep.irq(1'b1, 16'h0006);
        i_ep.irq(1'b0, 16'h0006);
        chk("irq_hit", rsp.irq_hit, 64'h1);
        i_ep.irq(1'b0, 16'h000A);
        chk("irq_hit other index", rsp.irq_hit, 64'h0);
        rd(REG_STATUS, d);
        chk("status irq only", 64'(d), 64'h4000);
        $display("test irq finished");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_tags();
        t_context();
        t_scalable();
        t_irq();
        wrap_up();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        wrap_up();
    end
endmodule
